// ==== core/msp_pkg.sv ====
// Constants, register map and types of the message serial slave port.
//
// Contract
// - Serial slave only, host clock up to 8MHz.
// - Configurable sample and update clock edges.
// - Every byte and word shifted MSB first.
// - Serial output undriven while not selected.
// - Status, length in words, then data words.
// - Device sends padding, then its status byte.
// - Status: bits 7:2 zero, queued, ready.
// - Non-zero length only if queued and peer ready.
// - Words move from lowest buffer address upward.
// - Two buffers of 64 words, moved by hardware.
// - Buffer and count written, attention then raised.
// - Attention drops at start, returns if unsent.
// - Maskable completion interrupt at select release.
// - Ready bit only after software arms reception.
// - Attention for earlier refused send once armed.
// - Transmit and receive buffers selected separately.
// - Port need not work during processor doze.
package msp_pkg;

  // ----------------------------------------------------------------
  // Clock and bus geometry.
  // ----------------------------------------------------------------
  localparam int PCLK_HZ = 40_000_000;
  localparam int LINK_MAX_HZ = 8_000_000;
  // System clock cycles in the shortest half period of the host clock.
  localparam int LINK_HALF_CYC = PCLK_HZ / (2 * LINK_MAX_HZ);
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_TXCMD = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_RXINFO = 12'h00C;
  // Buffer window: two buffers of 64 words at 0x200 to 0x3FF.
  localparam logic [2:0] MEM_WIN_TAG = 3'h1;

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int CTRL_EDGE = 0;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_RXBUF = 2;
  localparam int TXCMD_BUF = 8;
  localparam int STAT_TXQ = 0;
  localparam int STAT_RX_BUFFER_READY_FLAG = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_RXOK = 3;
  localparam int STAT_REFUSED = 4;
  localparam int STAT_ACTIVE = 5;
  localparam int SB_TXQ = 1;
  localparam int SB_RX_BUFFER_READY_FLAG = 0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Buffer and framing sizes.
  // ----------------------------------------------------------------
  localparam int BUF_WORDS = 64;
  localparam int MEM_AW = 7;
  localparam logic [6:0] MAX_WORDS = 7'h40;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] WORD_LAST = 5'h1F;

  // Frame phase of the current unit; Gray coded along the frame.
  typedef enum logic [1:0] {
    PH_PAD = 2'b00,
    PH_STAT = 2'b01,
    PH_LEN = 2'b11,
    PH_DATA = 2'b10
  } msp_phase_e;

endpackage

// ==== core/msp_buf_mem.sv ====
// Buffer memory with a bus port, a link read port and a link write port.
`timescale 1ns/1ps
module msp_buf_mem #(
  parameter int AW = 7,
  parameter int DW = 32
) (
  // Clock.
  input wire logic clk,
  // Bus port, read and write.
  input wire logic [AW-1:0] a_addr,
  input wire logic a_we,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  // Link read port.
  input wire logic [AW-1:0] b_raddr,
  output logic [DW-1:0] b_rdata,
  // Link write port.
  input wire logic [AW-1:0] c_waddr,
  input wire logic c_we,
  input wire logic [DW-1:0] c_wdata
);

  // Storage array; the link write is placed last so it wins a collision.
  logic [DW-1:0] mem [2**AW];

  // Writes and registered reads.
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (c_we) begin
      mem[c_waddr] <= c_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_raddr];
  end

endmodule // msp_buf_mem

// ==== core/msp_slave_port.sv ====
// Message serial slave port with APB registers and hardware buffers.
`timescale 1ns/1ps
module msp_slave_port import msp_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host link pins.
  input wire logic host_serial_clock,
  input wire logic host_port_select_n,
  input wire logic host_serial_in_line,
  output logic host_serial_out_line,
  output logic host_serial_out_oe,
  output logic host_attention_line,
  // Internal completion interrupt.
  output logic xfer_done_irq
);

  // ----------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------

  // True when the address falls in the buffer window.
  function automatic logic is_mem(input logic [11:0] a);
    return a[11:9] == MEM_WIN_TAG;
  endfunction

  // Clamps a received length to the size of one buffer.
  function automatic logic [6:0] clamp_len(input logic [7:0] n);
    return (n > {1'b0, MAX_WORDS}) ? MAX_WORDS : n[6:0];
  endfunction

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic [2:0] clk_sy; // Host clock synchroniser and edge history.
  logic [1:0] sel_sy; // Select synchroniser, active high after inversion.
  logic [1:0] din_sy; // Serial input synchroniser.
  logic rise; // Host clock rising edge seen.
  logic fall; // Host clock falling edge seen.
  logic samp; // Sample edge of the host clock.
  logic upd; // Update edge of the host clock.
  logic active_r; // Transfer in progress.
  logic stop; // Select released this cycle.
  logic edge_sel_r; // Edge choice: 0 samples on rise, 1 on fall.
  logic irq_en_r; // Completion interrupt mask.
  logic rx_buf_r; // Buffer that receives.
  logic tx_buf_r; // Buffer that transmits.
  logic [6:0] tx_cnt_r; // Queued word count.
  logic tx_q_r; // Data queued for transmission.
  logic rx_rdy_r; // Receive buffer armed.
  logic done_r; // Sticky transfer completion.
  logic rx_ok_r; // Sticky successful reception.
  logic refused_r; // Host was refused for lack of a ready buffer.
  logic [6:0] rx_count_r; // Words of the last good reception.
  logic attn_r; // Attention line register.
  logic irq_r; // Interrupt output register.
  logic pready_r; // APB ready register.
  logic pslverr_r; // APB error register.
  logic [31:0] prdata_r; // APB read data register.
  logic [31:0] rd_mux; // Register read selection.
  logic acc; // APB access phase.
  logic wr_ok; // APB write completes this cycle.
  msp_phase_e phase_r; // Phase of the unit being shifted.
  logic [4:0] bit_cnt_r; // Bits sampled in the current unit.
  logic [31:0] in_sr_r; // Input shift register.
  logic [31:0] in_nxt; // Input shift register with the new bit.
  logic [31:0] out_sr_r; // Output shift register, MSB on the pin.
  logic load_pend_r; // Next unit must load on the next update edge.
  logic host_txq_r; // Host reported queued data.
  logic host_rx_buffer_ready_flag_r; // Host reported a ready buffer.
  logic rx_adv_r; // Ready bit that was actually sent.
  logic [6:0] tx_len_r; // Length sent to the host.
  logic [6:0] rx_len_r; // Length accepted from the host.
  logic [6:0] tx_widx_r; // Next word to load for sending.
  logic [6:0] tx_sent_r; // Words fully shifted out.
  logic [6:0] rx_widx_r; // Words written into the receive buffer.
  logic unit_end; // Last bit of a unit sampled this cycle.
  logic [31:0] load_val; // Unit to load on the update edge.
  logic [7:0] stat_byte; // Outgoing status byte.
  logic [6:0] len_out; // Outgoing length field.
  logic rx_we; // Receive word written this cycle.
  logic [31:0] mem_a_rd; // Bus port read data.
  logic [31:0] mem_b_rd; // Link port read data.

  // ----------------------------------------------------------------
  // Host pin synchronisers and edge detection.
  // ----------------------------------------------------------------

  // Two flops per pin, three on the host clock; sampling at 40MHz keeps up with an 8MHz host clock,
  // though the output then trails the host edge by about three cycles.
  // No doze handling: the port simply is not offered while dozing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sy <= 3'h0;
      sel_sy <= 2'h0;
      din_sy <= 2'h0;
    end else begin
      clk_sy <= {clk_sy[1:0], host_serial_clock};
      sel_sy <= {sel_sy[0], ~host_port_select_n};
      din_sy <= {din_sy[0], host_serial_in_line};
    end
  end

  // Edge pulses from the synchronised host clock.
  assign rise = clk_sy[1] & ~clk_sy[2];
  assign fall = ~clk_sy[1] & clk_sy[2];
  // The edge setting decides which edge samples and which updates.
  assign samp = active_r & (edge_sel_r ? fall : rise);
  assign upd = active_r & (edge_sel_r ? rise : fall);

  // Transfer state follows the select line only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 1'b0;
    end else begin
      active_r <= sel_sy[1];
    end
  end
  assign stop = active_r & ~sel_sy[1];

  // ----------------------------------------------------------------
  // APB slave.
  // ----------------------------------------------------------------
  assign acc = psel & penable;
  assign wr_ok = acc & pready_r & pwrite;

  // Every access takes one wait state so buffer reads can settle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= RD_ZERO;
    end else begin
      pready_r <= acc & ~pready_r;
      if (acc & ~pready_r) begin
        // Unmapped addresses answer with an error and zero data.
        pslverr_r <= (rd_mux == RD_ZERO) && !is_mem(paddr) &&
                     (paddr > OFS_RXINFO || paddr[1:0] != 2'h0);
        prdata_r <= is_mem(paddr) ? mem_a_rd : rd_mux;
      end
    end
  end

  // Register read selection.
  always_comb begin
    rd_mux = RD_ZERO;
    unique case (paddr)
      OFS_CTRL: rd_mux = {29'h0, rx_buf_r, irq_en_r, edge_sel_r};
      OFS_TXCMD: rd_mux = {23'h0, tx_buf_r, 1'b0, tx_cnt_r};
      OFS_STAT: rd_mux = {26'h0, active_r, refused_r, rx_ok_r, done_r,
                          rx_rdy_r, tx_q_r};
      OFS_RXINFO: rd_mux = {25'h0, rx_count_r};
      default: rd_mux = RD_ZERO;
    endcase
  end

  // Control register: edge choice, interrupt mask, receive buffer.
  // Separate buffer selects keep the two directions apart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel_r <= 1'b0;
      irq_en_r <= 1'b0;
      rx_buf_r <= 1'b0;
    end else if (wr_ok && paddr == OFS_CTRL) begin
      edge_sel_r <= pwdata[CTRL_EDGE];
      irq_en_r <= pwdata[CTRL_IRQ_EN];
      rx_buf_r <= pwdata[CTRL_RXBUF];
    end
  end

  // Transmit command: buffer and count, queued flag set by the write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_r <= 1'b0;
      tx_cnt_r <= 7'h00;
      tx_q_r <= 1'b0;
    end else begin
      // A fully sent, uncut transfer retires the queued message.
      if (stop && tx_len_r != 7'h00 && tx_sent_r == tx_len_r) begin
        tx_q_r <= 1'b0;
      end
      if (wr_ok && paddr == OFS_TXCMD) begin
        tx_buf_r <= pwdata[TXCMD_BUF];
        tx_cnt_r <= clamp_len(pwdata[7:0]);
        tx_q_r <= pwdata[7:0] != 8'h00;
      end
    end
  end

  // Status flags; hardware sets are placed after software clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_rdy_r <= 1'b0;
      done_r <= 1'b0;
      rx_ok_r <= 1'b0;
      refused_r <= 1'b0;
      rx_count_r <= 7'h00;
    end else begin
      if (wr_ok && paddr == OFS_STAT) begin
        // Writing one to the ready bit arms reception.
        if (pwdata[STAT_RX_BUFFER_READY_FLAG]) begin
          rx_rdy_r <= 1'b1;
        end
        if (pwdata[STAT_DONE]) begin
          done_r <= 1'b0;
        end
        if (pwdata[STAT_RXOK]) begin
          rx_ok_r <= 1'b0;
        end
      end
      // Host wanted to send but saw no ready buffer.
      if (unit_end && phase_r == PH_STAT && host_txq_r && !rx_adv_r) begin
        refused_r <= 1'b1;
      end
      if (stop) begin
        done_r <= 1'b1;
        if (rx_adv_r) begin
          refused_r <= 1'b0;
        end
        // Only a reception that moved every word counts.
        if (rx_len_r != 7'h00 && rx_widx_r == rx_len_r) begin
          rx_ok_r <= 1'b1;
          rx_rdy_r <= 1'b0;
          rx_count_r <= rx_len_r;
        end
      end
    end
  end

  // Attention and completion interrupt outputs.
  // Attention falls while selected and returns if work remains.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attn_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      attn_r <= !sel_sy[1] && !active_r && (tx_q_r || (refused_r && rx_rdy_r));
      irq_r <= done_r & irq_en_r;
    end
  end

  // ----------------------------------------------------------------
  // Link framing and shifting.
  // ----------------------------------------------------------------
  assign in_nxt = {in_sr_r[30:0], din_sy[1]};
  assign unit_end = samp &&
                    (bit_cnt_r == ((phase_r == PH_DATA) ? WORD_LAST : BYTE_LAST));
  assign stat_byte = {6'h00, tx_q_r, rx_rdy_r};
  // Length is non-zero only for queued data and a ready host.
  assign len_out = (tx_q_r && host_rx_buffer_ready_flag_r) ? tx_cnt_r : 7'h00;
  assign rx_we = unit_end && phase_r == PH_DATA && rx_widx_r < rx_len_r;

  // Unit selected for the next update edge, by the new phase.
  always_comb begin
    load_val = RD_ZERO;
    unique case (phase_r)
      PH_PAD: load_val = RD_ZERO;
      PH_STAT: load_val = {stat_byte, 24'h00_0000};
      PH_LEN: load_val = {1'b0, len_out, 24'h00_0000};
      PH_DATA: load_val = (tx_widx_r < tx_len_r) ? mem_b_rd : RD_ZERO;
    endcase
  end

  // Frame sequencing, shift registers and word indices.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= PH_PAD;
      bit_cnt_r <= 5'h00;
      in_sr_r <= RD_ZERO;
      out_sr_r <= RD_ZERO;
      load_pend_r <= 1'b0;
      host_txq_r <= 1'b0;
      host_rx_buffer_ready_flag_r <= 1'b0;
      rx_adv_r <= 1'b0;
      tx_len_r <= 7'h00;
      rx_len_r <= 7'h00;
      tx_widx_r <= 7'h00;
      tx_sent_r <= 7'h00;
      rx_widx_r <= 7'h00;
    end else if (!active_r) begin
      // Idle: all positions restart; the padding byte waits on the pin.
      phase_r <= PH_PAD;
      bit_cnt_r <= 5'h00;
      out_sr_r <= RD_ZERO;
      load_pend_r <= 1'b0;
      host_txq_r <= 1'b0;
      host_rx_buffer_ready_flag_r <= 1'b0;
      rx_adv_r <= 1'b0;
      tx_len_r <= 7'h00;
      rx_len_r <= 7'h00;
      tx_widx_r <= 7'h00;
      tx_sent_r <= 7'h00;
      rx_widx_r <= 7'h00;
    end else begin
      // Incoming bits enter at the LSB, so the first bit ends as MSB.
      if (samp) begin
        in_sr_r <= in_nxt;
        bit_cnt_r <= unit_end ? 5'h00 : bit_cnt_r + 5'h01;
      end
      if (unit_end) begin
        load_pend_r <= 1'b1;
        unique case (phase_r)
          PH_PAD: begin
            // First incoming byte is the host status.
            host_txq_r <= in_nxt[SB_TXQ];
            host_rx_buffer_ready_flag_r <= in_nxt[SB_RX_BUFFER_READY_FLAG];
            phase_r <= PH_STAT;
          end
          PH_STAT: begin
            phase_r <= PH_LEN;
          end
          PH_LEN: begin
            // Host length is honoured only if ready was advertised.
            rx_len_r <= rx_adv_r ? clamp_len(in_nxt[7:0]) : 7'h00;
            phase_r <= PH_DATA;
          end
          PH_DATA: begin
            if (rx_widx_r < rx_len_r) begin
              rx_widx_r <= rx_widx_r + 7'h01;
            end
            if (tx_sent_r < tx_len_r) begin
              tx_sent_r <= tx_sent_r + 7'h01;
            end
          end
        endcase
      end
      if (upd) begin
        if (load_pend_r) begin
          load_pend_r <= 1'b0;
          out_sr_r <= load_val;
          if (phase_r == PH_STAT) begin
            rx_adv_r <= rx_rdy_r;
          end
          if (phase_r == PH_LEN) begin
            tx_len_r <= len_out;
          end
          if (phase_r == PH_DATA && tx_widx_r < tx_len_r) begin
            tx_widx_r <= tx_widx_r + 7'h01;
          end
        end else begin
          out_sr_r <= {out_sr_r[30:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer memory and outputs.
  // ----------------------------------------------------------------

  // Two 64-word buffers, one picked per direction; words moved by hardware.
  msp_buf_mem #(
    .AW(MEM_AW),
    .DW(32)
  ) u_mem (
    .clk(pclk),
    .a_addr(paddr[8:2]),
    .a_we(wr_ok && is_mem(paddr)),
    .a_wdata(pwdata),
    .a_rdata(mem_a_rd),
    .b_raddr({tx_buf_r, tx_widx_r[5:0]}),
    .b_rdata(mem_b_rd),
    .c_waddr({rx_buf_r, rx_widx_r[5:0]}),
    .c_we(rx_we),
    .c_wdata(in_nxt)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign host_serial_out_line = out_sr_r[31];
  // The pin is driven only while a transfer is active.
  assign host_serial_out_oe = active_r;
  assign host_attention_line = attn_r;
  assign xfer_done_irq = irq_r;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_xfer_start;
    !active_r ##1 active_r;
  endsequence

  sequence s_xfer_end;
    active_r ##1 !active_r;
  endsequence

  a_oe_idle: assert property (!sel_sy[1] |=> !host_serial_out_oe)
    else $error("serial output driven while not selected");
  a_status_format: assert property (upd && load_pend_r && phase_r == PH_STAT |=>
                                    out_sr_r[31:26] == 6'h00)
    else $error("status byte reserved bits not zero");
  a_len_gate: assert property (upd && load_pend_r && phase_r == PH_LEN &&
                               !(tx_q_r && host_rx_buffer_ready_flag_r) |=> out_sr_r[31:24] == 8'h00)
    else $error("non-zero length without queued data and ready host");
  a_attn_drop: assert property (s_xfer_start |-> !host_attention_line)
    else $error("attention still high during transfer");
  a_done_flag: assert property (s_xfer_end |-> done_r)
    else $error("completion flag not set at select release");
  a_irq_mask: assert property (done_r && irq_en_r |=> xfer_done_irq)
    else $error("unmasked completion did not raise interrupt");
  a_counter_restart: assert property (s_xfer_start |-> bit_cnt_r == 5'h00 &&
                                      phase_r == PH_PAD && tx_widx_r == 7'h00)
    else $error("position counters not cleared at start");
  a_msb_shift: assert property (upd && !load_pend_r |=>
                                host_serial_out_line == $past(out_sr_r[30]))
    else $error("output not shifted MSB first");
  a_ready_adv: assert property (upd && load_pend_r && phase_r == PH_STAT |=>
                                out_sr_r[24] == $past(rx_rdy_r))
    else $error("ready bit sent without armed buffer");
  a_pad_first: assert property (s_xfer_start |-> !host_serial_out_line)
    else $error("first output bit is not padding");
  a_edge_space: assert property (rise |-> ##1 !rise [*2])
    else $error("host clock edges closer than synchroniser allows");
  a_apb_wait: assert property (acc && !pready_r |=> pready_r)
    else $error("APB access not answered after one wait state");

endmodule // msp_slave_port

// ==== bench/msp_host_model.sv ====
// Behavioural host serial master that frames transfers on the link.
`timescale 1ns/1ps
module msp_host_model (
  // System clock used as the time base.
  input wire logic pclk,
  // Link pins.
  output logic host_serial_clock,
  output logic host_serial_in_line,
  output logic host_port_select_n,
  input wire logic host_serial_out_line
);
  logic [7:0] tx_b [0:10]; // Bytes sent to the device.
  logic [7:0] rx_b [0:10]; // Bytes seen from the device.
  logic inv = 1'b0; // Idle clock level, high for the other edge mode.
  logic clk_raw = 1'b0; // Clock before the idle level is applied.
  assign host_serial_clock = clk_raw ^ inv;
  initial begin
    host_port_select_n = 1'b1;
    host_serial_in_line = 1'b0;
  end
  // One frame of n bytes, MSB first; the clock stands still outside it.
  task run(input int n);
    @(posedge pclk);
    host_port_select_n <= 1'b0;
    host_serial_in_line <= tx_b[0][7];
    repeat (6) @(posedge pclk);
    for (int i = 0; i < n * 8; i++) begin
      clk_raw <= 1'b1;
      repeat (3) @(posedge pclk);
      rx_b[i / 8][7 - i % 8] = host_serial_out_line;
      @(posedge pclk);
      clk_raw <= 1'b0;
      if (i + 1 < n * 8) host_serial_in_line <= tx_b[(i + 1) / 8][7 - (i + 1) % 8];
      repeat (4) @(posedge pclk);
    end
    // Released line shows the inverse; select stays high over 300 ns.
    host_port_select_n <= 1'b1;
    host_serial_in_line <= ~host_serial_in_line;
    repeat (14) @(posedge pclk);
  endtask
endmodule // msp_host_model

// ==== bench/tb.sv ====
// Self-checking bench for the message serial slave port.
`timescale 1ns/1ps
module tb;
  import msp_pkg::*;
  // Bus and link signals.
  logic pclk = 1'b0;
  logic presetn;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, sclk, seln, sdi, sdo, soe, attn, irq;
  int fail_count = 0;
  int checked = 0;
  always #12.5 pclk = ~pclk;
  msp_slave_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_serial_clock(sclk), .host_port_select_n(seln),
    .host_serial_in_line(sdi), .host_serial_out_line(sdo), .host_serial_out_oe(soe),
    .host_attention_line(attn), .xfer_done_irq(irq));
  msp_host_model host (.pclk(pclk), .host_serial_clock(sclk), .host_serial_in_line(sdi),
    .host_port_select_n(seln), .host_serial_out_line(sdo));
  // Compares a seen value with the expected one.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; read data is taken at the edge where pready is high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fail_count++;
      $display("[FAIL] %0t bus timeout", $time);
      stop_test;
    end
  endtask
  // Reads the status register and compares it.
  task st(input logic [31:0] e);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk(rdat, e);
  endtask
  // Loads the eleven host bytes, first byte in the top bits.
  task hset(input logic [87:0] v);
    for (int i = 0; i < 11; i++) host.tx_b[i] = v[87 - 8 * i -: 8];
  endtask
  // Main sequence.
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    st(32'h0000_0000);
    chk(attn, 1'b0);
    chk(soe, 1'b0);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0000_0000);
    $display("Test reset done");
    hset(88'h01_0000_0000_0000_0000_0000);
    host.run(2);
    chk(host.rx_b[0], 8'h00);
    chk(host.rx_b[1], 8'h00);
    chk(soe, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    st(32'h0000_0004);
    chk(irq, 1'b1);
    apb(1'b1, OFS_STAT, 32'h0000_0004);
    st(32'h0000_0000);
    chk(irq, 1'b0);
    $display("Test idle frame done");
    apb(1'b1, 12'h200, 32'h1234_5678);
    apb(1'b1, 12'h204, 32'hA5C3_0F96);
    apb(1'b1, OFS_TXCMD, 32'h0000_0002);
    st(32'h0000_0001);
    chk(attn, 1'b1);
    host.run(11);
    for (int i = 0; i < 11; i++) chk(host.rx_b[i], 88'h00_0202_1234_5678_A5C3_0F96 >> (80 - 8 * i) & 8'hFF);
    st(32'h0000_0004);
    chk(attn, 1'b0);
    apb(1'b1, OFS_TXCMD, 32'h0000_0001);
    host.run(3);
    st(32'h0000_0005);
    chk(attn, 1'b1);
    apb(1'b1, OFS_TXCMD, 32'h0000_0000);
    apb(1'b1, OFS_STAT, 32'h0000_0004);
    $display("Test transmit done");
    apb(1'b1, OFS_CTRL, 32'h0000_0006);
    apb(1'b1, OFS_STAT, 32'h0000_0002);
    hset(88'h02_0001_DEAD_BEEF_0000_0000);
    host.run(7);
    chk(host.rx_b[1], 8'h01);
    chk(host.rx_b[2], 8'h00);
    apb(1'b0, 12'h300, 32'h0000_0000);
    chk(rdat, 32'hDEAD_BEEF);
    apb(1'b0, OFS_RXINFO, 32'h0000_0000);
    chk(rdat, 32'h0000_0001);
    st(32'h0000_000C);
    chk(irq, 1'b1);
    apb(1'b1, OFS_STAT, 32'h0000_000C);
    $display("Test receive done");
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    host.inv <= 1'b1;
    hset(88'h02_0000_0000_0000_0000_0000);
    host.run(2);
    chk(host.rx_b[1], 8'h00);
    st(32'h0000_0014);
    chk(attn, 1'b0);
    apb(1'b1, OFS_STAT, 32'h0000_0006);
    st(32'h0000_0012);
    chk(attn, 1'b1);
    hset(88'h00_0000_0000_0000_0000_0000);
    host.run(2);
    chk(host.rx_b[1], 8'h01);
    st(32'h0000_0006);
    chk(attn, 1'b0);
    $display("Test refused send done");
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    apb(1'b1, OFS_TXCMD, 32'h0000_0101);
    hset(88'h03_0001_CAFE_F00D_0000_0000);
    host.run(7);
    chk(host.rx_b[1], 8'h03);
    chk(host.rx_b[2], 8'h01);
    for (int i = 0; i < 4; i++) chk(host.rx_b[3 + i], 32'hDEAD_BEEF >> (24 - 8 * i) & 8'hFF);
    apb(1'b0, 12'h200, 32'h0000_0000);
    chk(rdat, 32'hCAFE_F00D);
    apb(1'b0, 12'h300, 32'h0000_0000);
    chk(rdat, 32'hDEAD_BEEF);
    st(32'h0000_000C);
    chk(attn, 1'b0);
    $display("Test dual direction done");
    stop_test;
  end
endmodule // tb
